// ---- hdl/aecl_latch_ctrl.sv ----
/*
 * Alarm, error and counter latch configuration block of one receiver.
 * Holds the latch configuration register, the error counters that it
 * governs and the alarm and error interrupt status bytes.
 * Assumes a synchronous processor port with one-cycle read and write
 * strobes, and a one-cycle one_second_tick pulse from the framer timer.
 */
`timescale 1ns/1ns
`include "aecl_params.svh"

module aecl_latch_ctrl (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Processor port
   input wire aecl_pkg::aecl_cpu_req_t cpu_req,
   output logic [7:0] cpu_rdata,
   // Receive conditions and timer
   input wire aecl_pkg::aecl_alarm_t alarms,
   input wire logic one_second_tick,
   input wire logic e1_mode,
   input wire logic frame_loss_cnt_ovf,
   // Counter events
   input wire logic [3:0] err_event,
   input wire logic test_pattern_error,
   input wire logic alarm_event,
   // Interrupt sources and their types, 1 meaning any transition
   input wire logic [7:0] alarm_cond,
   input wire logic [7:0] alarm_any_edge,
   input wire logic [7:0] error_cond,
   // Outputs to the rest of the receiver
   output logic perf_monitor_en,
   output logic mfa_timeout_valid,
   output logic [7:0] alarm_irq_status_a,
   output logic [7:0] alarm_irq_status_b
);

   // ****************************************************************
   // Decode
   // ****************************************************************
   function automatic logic fn_hit(input logic [7:0] addr, input logic [7:0] off);
      fn_hit = (addr == off);
   endfunction : fn_hit

   // Sticky status; the set term always wins over the clear term.
   function automatic logic [7:0] fn_status_next(input logic [7:0] cur,
         input logic [7:0] ev, input logic hold_sel, input logic tick, input logic rd);
      logic clr;
      clr = hold_sel ? tick : rd;
      fn_status_next = clr ? ev : (cur | ev);
   endfunction : fn_status_next

   logic [7:0] cfg_q;
   logic [7:0] alarm_prev_q;
   logic [7:0] error_prev_q;
   logic [7:0] irq_a_q;
   logic [7:0] irq_b_q;
   logic [7:0] rdata_q;
   aecl_pkg::aecl_cfg_t cfg;

   assign cfg.count_freeze_on_alarm = cfg_q[`AECL_BIT_FREEZE];
   assign cfg.count_hold_select = cfg_q[`AECL_BIT_CNT_HOLD];
   assign cfg.error_hold_select = cfg_q[`AECL_BIT_ERR_HOLD];
   assign cfg.alarm_hold_select = cfg_q[`AECL_BIT_ALM_HOLD];

   wire rd = cpu_req.rd;
   wire wr_cfg = cpu_req.wr && fn_hit(cpu_req.addr, `AECL_OFF_LATCH_CFG);
   wire rd_irq_a = rd && fn_hit(cpu_req.addr, `AECL_OFF_IRQ_A);
   wire rd_irq_b = rd && fn_hit(cpu_req.addr, `AECL_OFF_IRQ_B);

   // ****************************************************************
   // Alarm gating
   // ****************************************************************
   wire rx_alarm = alarms.rx_frame_loss | alarms.rx_signal_loss | alarms.rx_all_ones_alarm;
   wire freeze = cfg.count_freeze_on_alarm & rx_alarm;
   // A yellow group alarm alone leaves monitoring running.
   assign perf_monitor_en = ~alarms.cga_red_ais;
   // In E1 mode held counts no longer track real time, so the overflow cannot time alignment.
   assign mfa_timeout_valid = frame_loss_cnt_ovf & ~(e1_mode & cfg.count_hold_select);

   // ****************************************************************
   // Counters
   // ****************************************************************
   logic [7:0] err_lo [`AECL_NUM_ERR_CNT];
   logic [7:0] err_hi [`AECL_NUM_ERR_CNT];
   logic [7:0] test_lo;
   logic [7:0] test_hi;
   logic [7:0] evt_lo;

   genvar gi;
   generate
      for (gi = 0; gi < `AECL_NUM_ERR_CNT; gi++) begin : g_err
         wire [7:0] lo_off = `AECL_OFF_ERR_BASE + 8'(2 * gi);
         wire [7:0] hi_off = `AECL_OFF_ERR_BASE + 8'(2 * gi + 1);
         aecl_err_counter u_cnt (
            .ref_clk(ref_clk),
            .rst(rst),
            .inc(err_event[gi] & perf_monitor_en),
            .freeze(freeze),
            .hold_sel(cfg.count_hold_select),
            .one_second_tick(one_second_tick),
            .rd_lo(rd && fn_hit(cpu_req.addr, lo_off)),
            .rd_hi(rd && fn_hit(cpu_req.addr, hi_off)),
            .lo_val(err_lo[gi]),
            .hi_val(err_hi[gi])
         );
      end
   endgenerate

   // The freeze never reaches these two counters.
   aecl_err_counter u_test_cnt (
      .ref_clk(ref_clk),
      .rst(rst),
      .inc(test_pattern_error),
      .freeze(1'b0),
      .hold_sel(cfg.count_hold_select),
      .one_second_tick(one_second_tick),
      .rd_lo(rd && fn_hit(cpu_req.addr, `AECL_OFF_TEST_LO)),
      .rd_hi(rd && fn_hit(cpu_req.addr, `AECL_OFF_TEST_HI)),
      .lo_val(test_lo),
      .hi_val(test_hi)
   );

   aecl_err_counter u_evt_cnt (
      .ref_clk(ref_clk),
      .rst(rst),
      .inc(alarm_event),
      .freeze(1'b0),
      .hold_sel(cfg.count_hold_select),
      .one_second_tick(one_second_tick),
      .rd_lo(rd && fn_hit(cpu_req.addr, `AECL_OFF_ALM_EVT)),
      .rd_hi(1'b0),
      .lo_val(evt_lo),
      .hi_val()
   );

   // ****************************************************************
   // Interrupt status
   // ****************************************************************
   wire [7:0] alarm_rise = alarm_cond & ~alarm_prev_q;
   wire [7:0] alarm_flip = alarm_cond ^ alarm_prev_q;
   wire [7:0] alarm_ev = (alarm_any_edge & alarm_flip) | (~alarm_any_edge & alarm_rise);
   wire [7:0] error_ev = error_cond & ~error_prev_q;
   wire [7:0] irq_a_d =
      fn_status_next(irq_a_q, alarm_ev, cfg.alarm_hold_select, one_second_tick, rd_irq_a);
   wire [7:0] irq_b_d =
      fn_status_next(irq_b_q, error_ev, cfg.error_hold_select, one_second_tick, rd_irq_b);

   assign alarm_irq_status_a = irq_a_q;
   assign alarm_irq_status_b = irq_b_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         alarm_prev_q <= `AECL_BYTE_ZERO;
         error_prev_q <= `AECL_BYTE_ZERO;
         irq_a_q <= `AECL_BYTE_ZERO;
         irq_b_q <= `AECL_BYTE_ZERO;
      end else begin
         alarm_prev_q <= alarm_cond;
         error_prev_q <= error_cond;
         irq_a_q <= irq_a_d;
         irq_b_q <= irq_b_d;
      end
   end

   // ****************************************************************
   // Register access
   // ****************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= `AECL_CFG_RESET;
      end else if (wr_cfg) begin
         // Reserved bits are expected as zero and are not stored.
         cfg_q <= cpu_req.wdata & `AECL_CFG_USED_MASK;
      end
   end

   logic [7:0] rmux;
   always_comb begin
      rmux = `AECL_BYTE_ZERO;
      if (fn_hit(cpu_req.addr, `AECL_OFF_LATCH_CFG)) rmux = cfg_q;
      if (fn_hit(cpu_req.addr, `AECL_OFF_IRQ_A)) rmux = irq_a_q;
      if (fn_hit(cpu_req.addr, `AECL_OFF_IRQ_B)) rmux = irq_b_q;
      if (fn_hit(cpu_req.addr, `AECL_OFF_TEST_LO)) rmux = test_lo;
      if (fn_hit(cpu_req.addr, `AECL_OFF_TEST_HI)) rmux = test_hi;
      if (fn_hit(cpu_req.addr, `AECL_OFF_ALM_EVT)) rmux = evt_lo;
      for (int i = 0; i < `AECL_NUM_ERR_CNT; i++) begin
         if (fn_hit(cpu_req.addr, `AECL_OFF_ERR_BASE + 8'(2 * i))) rmux = err_lo[i];
         if (fn_hit(cpu_req.addr, `AECL_OFF_ERR_BASE + 8'(2 * i + 1))) rmux = err_hi[i];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= `AECL_BYTE_ZERO;
      end else if (rd) begin
         rdata_q <= rmux;
      end
   end
   assign cpu_rdata = rdata_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_cfg_reserved;
      @(posedge ref_clk) disable iff (rst)
         wr_cfg |=> (cfg_q & ~`AECL_CFG_USED_MASK) == `AECL_BYTE_ZERO;
   endproperty
   a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved bit stored");

   property p_set_wins;
      @(posedge ref_clk) disable iff (rst)
         rd_irq_a && !cfg.alarm_hold_select && alarm_ev != `AECL_BYTE_ZERO
            |=> (irq_a_q & $past(alarm_ev)) == $past(alarm_ev);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("alarm event lost on clear");

   property p_alarm_held;
      @(posedge ref_clk) disable iff (rst)
         cfg.alarm_hold_select && rd_irq_a && !one_second_tick |=> irq_a_q == ($past(irq_a_q)
            | $past(alarm_ev));
   endproperty
   a_alarm_held: assert property (p_alarm_held) else $error("alarm status cleared by read");

   property p_err_clear;
      @(posedge ref_clk) disable iff (rst)
         !cfg.error_hold_select && rd_irq_b |=> irq_b_q == $past(error_ev);
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error status not read-cleared");

   property p_edge_type;
      @(posedge ref_clk) disable iff (rst)
         alarm_any_edge[0] && $fell(alarm_cond[0]) && !rd_irq_a && !one_second_tick
            |=> irq_a_q[0];
   endproperty
   a_edge_type: assert property (p_edge_type) else $error("falling transition missed");

   property p_mfa_void;
      @(posedge ref_clk) disable iff (rst)
         e1_mode && cfg.count_hold_select |-> !mfa_timeout_valid;
   endproperty
   a_mfa_void: assert property (p_mfa_void) else $error("timeout valid with held counts");

   property p_yellow_runs;
      @(posedge ref_clk) disable iff (rst)
         alarms.cga_yellow && !alarms.cga_red_ais |-> perf_monitor_en;
   endproperty
   a_yellow_runs: assert property (p_yellow_runs) else $error("yellow alarm stopped monitoring");

   property p_rd_data;
      @(posedge ref_clk) disable iff (rst)
         rd && fn_hit(cpu_req.addr, `AECL_OFF_LATCH_CFG) && !cpu_req.wr |=> cpu_rdata == $past(cfg_q);
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("config readback wrong");

endmodule : aecl_latch_ctrl

// ---- include/aecl_params.svh ----
/*
 * Offsets, field positions, reset values and sizes of the alarm, error and
 * counter latch configuration block.
 * Assumes an 8-bit address space on the parallel processor port.
 */
`ifndef AECL_PARAMS_SVH
`define AECL_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define AECL_OFF_LATCH_CFG 8'h46
`define AECL_OFF_IRQ_A 8'h04
`define AECL_OFF_IRQ_B 8'h05
`define AECL_OFF_ERR_BASE 8'h50
`define AECL_OFF_TEST_LO 8'h58
`define AECL_OFF_TEST_HI 8'h59
`define AECL_OFF_ALM_EVT 8'h5A

// ****************************************************************
// Latch configuration fields and reset value
// ****************************************************************
`define AECL_BIT_ALM_HOLD 0
`define AECL_BIT_ERR_HOLD 1
`define AECL_BIT_CNT_HOLD 2
`define AECL_BIT_FREEZE 3
`define AECL_CFG_USED_MASK 8'h0F
`define AECL_CFG_RESET 8'h00

// ****************************************************************
// Sizes and counter constants
// ****************************************************************
`define AECL_NUM_ERR_CNT 4
`define AECL_CNT_MAX 16'hFFFF
`define AECL_CNT_ZERO 16'h0000
`define AECL_BYTE_ZERO 8'h00
`define AECL_CNT_ONE 16'h0001

`endif

// ---- include/aecl_pkg.sv ----
/*
 * Types shared by the latch configuration block, the host model and the bench.
 * Assumes aecl_params.svh supplies all numeric constants.
 */
package aecl_pkg;

   // Processor port request, sampled on ref_clk.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } aecl_cpu_req_t;

   // Receive alarm conditions as seen by this block.
   typedef struct packed {
      logic rx_frame_loss;
      logic rx_signal_loss;
      logic rx_all_ones_alarm;
      logic cga_red_ais;
      logic cga_yellow;
   } aecl_alarm_t;

   // Decoded latch configuration.
   typedef struct packed {
      logic count_freeze_on_alarm;
      logic count_hold_select;
      logic error_hold_select;
      logic alarm_hold_select;
   } aecl_cfg_t;

endpackage : aecl_pkg

// ---- hdl/aecl_err_counter.sv ----
/*
 * One 16-bit error counter read as a low and a high byte, with freeze,
 * one-second hold and low-then-high read-and-clear behaviour.
 * Assumes rd_lo and rd_hi are one-cycle pulses from the processor port.
 */
`timescale 1ns/1ns
`include "aecl_params.svh"

module aecl_err_counter (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Count control
   input wire logic inc,
   input wire logic freeze,
   input wire logic hold_sel,
   input wire logic one_second_tick,
   // Read strobes
   input wire logic rd_lo,
   input wire logic rd_hi,
   // Read values
   output logic [7:0] lo_val,
   output logic [7:0] hi_val
);

   logic [15:0] live_q;
   logic [15:0] live_d;
   logic [15:0] held_q;
   logic [7:0] shadow_q;
   wire count_en = inc & ~freeze;
   wire clr_live = hold_sel ? one_second_tick : rd_lo;
   wire [15:0] base = clr_live ? `AECL_CNT_ZERO : live_q;
   // An event in the clearing cycle is counted into the new interval.
   wire sat = (base == `AECL_CNT_MAX);

   assign live_d = (count_en && !sat) ? base + `AECL_CNT_ONE : base;
   assign lo_val = hold_sel ? held_q[7:0] : live_q[7:0];
   assign hi_val = hold_sel ? held_q[15:8] : shadow_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         live_q <= `AECL_CNT_ZERO;
      end else begin
         live_q <= live_d;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         held_q <= `AECL_CNT_ZERO;
      end else if (hold_sel && one_second_tick) begin
         held_q <= live_q;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shadow_q <= `AECL_BYTE_ZERO;
      end else if (!hold_sel && rd_lo) begin
         shadow_q <= live_q[15:8];
      end else if (!hold_sel && rd_hi) begin
         shadow_q <= `AECL_BYTE_ZERO;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_lo_read;
      !hold_sel && rd_lo && !count_en;
   endsequence

   property p_freeze_hold;
      @(posedge ref_clk) disable iff (rst)
         freeze && !clr_live |=> live_q == $past(live_q);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("count moved while frozen");

   property p_lo_clear;
      @(posedge ref_clk) disable iff (rst)
         s_lo_read |=> live_q == `AECL_CNT_ZERO && shadow_q == $past(live_q[15:8]);
   endproperty
   a_lo_clear: assert property (p_lo_clear) else $error("low read did not clear");

   property p_hi_clear;
      @(posedge ref_clk) disable iff (rst)
         !hold_sel && rd_hi && !rd_lo |-> hi_val == shadow_q ##1 shadow_q == `AECL_BYTE_ZERO;
   endproperty
   a_hi_clear: assert property (p_hi_clear) else $error("high read did not clear");

   property p_hold_snap;
      @(posedge ref_clk) disable iff (rst)
         hold_sel && one_second_tick ##1 hold_sel && !one_second_tick
            |-> lo_val == $past(live_q[7:0], 1) && hi_val == $past(live_q[15:8], 1);
   endproperty
   a_hold_snap: assert property (p_hold_snap) else $error("tick did not hold count");

endmodule : aecl_err_counter

// ---- testbench/aecl_host_model.sv ----
/*
 * Host processor model that drives the parallel port of the latch block.
 * Assumes the bench calls its tasks one at a time and shares ref_clk.
 */
`timescale 1ns/1ns
`include "aecl_params.svh"

module aecl_host_model (
   // Clock
   input wire logic ref_clk,
   // Software state
   input wire logic e1_mode,
   input wire logic auto_perf_report,
   // Processor port
   output aecl_pkg::aecl_cpu_req_t cpu_req
);
   initial cpu_req = '0;

   // Software may wait a little before each access, so the port sees both
   // prompt and slow hosts.
   task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] d;
      d = (addr == `AECL_OFF_LATCH_CFG) ? (data & `AECL_CFG_USED_MASK) : data;
      if (addr == `AECL_OFF_LATCH_CFG && !e1_mode && auto_perf_report) begin
         d[`AECL_BIT_CNT_HOLD] = 1'b1;
      end
      repeat ($urandom_range(2)) @(posedge ref_clk);
      @(posedge ref_clk);
      cpu_req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: d};
      @(posedge ref_clk);
      cpu_req <= '0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] addr);
      repeat ($urandom_range(2)) @(posedge ref_clk);
      @(posedge ref_clk);
      cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
      @(posedge ref_clk);
      cpu_req <= '0;
   endtask : rd_reg
endmodule : aecl_host_model

// ---- testbench/tb_top.sv ----
/*
 * Self-checking bench for the latch configuration block.
 * Assumes the host model owns the processor port and that read data is
 * valid in the cycle after the edge that takes the read.
 */
`timescale 1ns/1ns
`include "aecl_params.svh"

module tb_top;
   // ******************************
   // Signals
   // ******************************
   logic ref_clk, rst, one_second_tick, e1_mode, frame_loss_cnt_ovf;
   logic test_pattern_error, alarm_event, perf_monitor_en, mfa_timeout_valid, taken;
   logic auto_perf_report;
   logic [3:0] err_event;
   logic [7:0] cpu_rdata, alarm_cond, alarm_any_edge, error_cond;
   logic [7:0] alarm_irq_status_a, alarm_irq_status_b;
   aecl_pkg::aecl_cpu_req_t cpu_req;
   aecl_pkg::aecl_alarm_t alarms;
   logic [7:0] exp_q[$];
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   int n;

   aecl_latch_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .cpu_req(cpu_req),
      .cpu_rdata(cpu_rdata), .alarms(alarms), .one_second_tick(one_second_tick),
      .e1_mode(e1_mode), .frame_loss_cnt_ovf(frame_loss_cnt_ovf),
      .err_event(err_event), .test_pattern_error(test_pattern_error),
      .alarm_event(alarm_event), .alarm_cond(alarm_cond),
      .alarm_any_edge(alarm_any_edge), .error_cond(error_cond),
      .perf_monitor_en(perf_monitor_en), .mfa_timeout_valid(mfa_timeout_valid),
      .alarm_irq_status_a(alarm_irq_status_a), .alarm_irq_status_b(alarm_irq_status_b));

   aecl_host_model host_u (.ref_clk(ref_clk), .e1_mode(e1_mode),
      .auto_perf_report(auto_perf_report), .cpu_req(cpu_req));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ******************************
   // Checking and helpers
   // ******************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   // Read data is compared half a cycle after the taking edge has landed.
   always @(posedge ref_clk) taken <= cpu_req.rd;
   always @(negedge ref_clk) begin
      if (taken === 1'b1) begin
         check(cpu_rdata, exp_q.pop_front());
      end
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end

   task automatic rd_exp(input logic [7:0] addr, input logic [7:0] exp);
      exp_q.push_back(exp);
      host_u.rd_reg(addr);
   endtask : rd_exp

   task automatic pulse(input logic [3:0] ev, input logic tp, input logic ae, input int cnt);
      repeat (cnt) begin
         @(posedge ref_clk);
         err_event <= ev;
         test_pattern_error <= tp;
         alarm_event <= ae;
         @(posedge ref_clk);
         err_event <= 4'h0;
         test_pattern_error <= 1'b0;
         alarm_event <= 1'b0;
      end
   endtask : pulse

   task automatic tick();
      @(posedge ref_clk);
      one_second_tick <= 1'b1;
      @(posedge ref_clk);
      one_second_tick <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : tick

   // ******************************
   // Tests
   // ******************************
   initial begin
      rst = 1'b1;
      auto_perf_report = 1'b0;
      alarms = '0;
      {one_second_tick, e1_mode, frame_loss_cnt_ovf, test_pattern_error, alarm_event} = '0;
      err_event = 4'h0;
      {alarm_cond, alarm_any_edge, error_cond} = '0;
      n = $urandom(32'h1f0f);
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      rd_exp(`AECL_OFF_LATCH_CFG, `AECL_CFG_RESET);
      rd_exp(`AECL_OFF_IRQ_A, 8'h00);
      rd_exp(`AECL_OFF_IRQ_B, 8'h00);
      rd_exp(8'h30, 8'h00);
      for (int v = 0; v < 16; v++) begin
         n = $urandom;
         host_u.wr_reg(`AECL_OFF_LATCH_CFG, {n[3:0], v[3:0]});
         rd_exp(`AECL_OFF_LATCH_CFG, {4'h0, v[3:0]});
      end
      // The host samples its report setting when a write starts, so let it settle first.
      auto_perf_report <= 1'b1;
      @(posedge ref_clk);
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h00);
      rd_exp(`AECL_OFF_LATCH_CFG, 8'h04);
      auto_perf_report <= 1'b0;
      @(posedge ref_clk);
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h00);
      $display("test register access done");
      // The fifth pass lands on the test pattern counter.
      for (int i = 0; i < 5; i++) begin
         n = $urandom_range(300, 1);
         pulse((i < 4) ? 4'(1 << i) : 4'h0, i == 4, 1'b0, n);
         rd_exp(`AECL_OFF_ERR_BASE + 8'(2 * i), 8'(n));
         rd_exp(`AECL_OFF_ERR_BASE + 8'(2 * i + 1), 8'(n >> 8));
         rd_exp(`AECL_OFF_ERR_BASE + 8'(2 * i + 1), 8'h00);
         rd_exp(`AECL_OFF_ERR_BASE + 8'(2 * i), 8'h00);
      end
      $display("test read and clear done");
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h08);
      for (int k = 0; k < 3; k++) begin
         alarms <= 5'h10 >> k;
         pulse(4'h1, 1'b1, 1'b1, 3);
         rd_exp(`AECL_OFF_ERR_BASE, 8'h00);
         rd_exp(`AECL_OFF_TEST_LO, 8'h03);
      end
      rd_exp(`AECL_OFF_ALM_EVT, 8'h09);
      alarms <= '0;
      pulse(4'h1, 1'b0, 1'b0, 2);
      rd_exp(`AECL_OFF_ERR_BASE, 8'h02);
      $display("test freeze done");
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h00);
      alarms <= 5'h02;
      pulse(4'h2, 1'b0, 1'b0, 4);
      check(perf_monitor_en, 1'b0);
      rd_exp(8'h52, 8'h00);
      alarms <= 5'h01;
      pulse(4'h2, 1'b0, 1'b0, 4);
      check(perf_monitor_en, 1'b1);
      rd_exp(8'h52, 8'h04);
      alarms <= '0;
      $display("test group alarm done");
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h04);
      pulse(4'h8, 1'b0, 1'b0, 7);
      tick();
      pulse(4'h8, 1'b0, 1'b0, 2);
      rd_exp(8'h56, 8'h07);
      rd_exp(8'h57, 8'h00);
      rd_exp(8'h56, 8'h07);
      tick();
      rd_exp(8'h56, 8'h02);
      frame_loss_cnt_ovf <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         e1_mode <= c[1];
         host_u.wr_reg(`AECL_OFF_LATCH_CFG, {5'h00, c[0], 2'h0});
         @(posedge ref_clk);
         check(mfa_timeout_valid, !(c[1] && c[0]));
      end
      $display("test count hold done");
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h00);
      e1_mode <= 1'b0;
      frame_loss_cnt_ovf <= 1'b0;
      alarm_any_edge <= 8'h01;
      alarm_cond <= 8'h03;
      repeat (3) @(posedge ref_clk);
      check(alarm_irq_status_a, 8'h03);
      rd_exp(`AECL_OFF_IRQ_A, 8'h03);
      rd_exp(`AECL_OFF_IRQ_A, 8'h00);
      alarm_cond <= 8'h00;
      repeat (3) @(posedge ref_clk);
      rd_exp(`AECL_OFF_IRQ_A, 8'h01);
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h01);
      alarm_cond <= 8'h02;
      repeat (3) @(posedge ref_clk);
      rd_exp(`AECL_OFF_IRQ_A, 8'h02);
      rd_exp(`AECL_OFF_IRQ_A, 8'h02);
      tick();
      rd_exp(`AECL_OFF_IRQ_A, 8'h00);
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h02);
      error_cond <= 8'h04;
      repeat (3) @(posedge ref_clk);
      check(alarm_irq_status_b, 8'h04);
      rd_exp(`AECL_OFF_IRQ_B, 8'h04);
      rd_exp(`AECL_OFF_IRQ_B, 8'h04);
      tick();
      rd_exp(`AECL_OFF_IRQ_B, 8'h00);
      host_u.wr_reg(`AECL_OFF_LATCH_CFG, 8'h00);
      error_cond <= 8'h0C;
      repeat (3) @(posedge ref_clk);
      rd_exp(`AECL_OFF_IRQ_B, 8'h08);
      rd_exp(`AECL_OFF_IRQ_B, 8'h00);
      repeat (3) @(posedge ref_clk);
      $display("test interrupt status done");
      summarize();
   end
endmodule : tb_top
